/* logic/gsrp_pkg.sv */
package gsrp_pkg;
  // Status byte layout
  localparam int unsigned STB_W = 8;
  localparam int unsigned BIT_RQS = 7;
  localparam int unsigned BIT_ERR = 6;
  localparam int unsigned BIT_RDY = 5;
  localparam int unsigned BIT_OUT = 4;
  localparam int unsigned BIT_USR = 3;
  localparam int unsigned ABN_HI = 2;
  localparam int unsigned ABN_LO = 1;
  localparam logic [7:0] STB_RESET = 8'h00;
  // Abnormality codes
  localparam logic [1:0] ABN_INTERP = 2'h0;
  localparam logic [1:0] ABN_EXEC = 2'h1;
  localparam logic [1:0] ABN_CAL = 2'h2;
  localparam logic [1:0] ABN_LONG = 2'h3;
  // Overlong message limit in characters
  localparam logic [7:0] MSG_MAX = 8'h4c;
  // Enable mask bit positions in the service request enable command
  localparam int unsigned EN_ERR = 0;
  localparam int unsigned EN_OUT = 1;
  localparam int unsigned EN_USR = 2;
  localparam int unsigned EN_RDY = 3;
  localparam logic [3:0] EN_RESET = 4'h0;
  // Parallel poll enable field layout
  localparam int unsigned PPE_SENSE = 3;
  localparam logic [2:0] PPL_RESET = 3'h0;
  // Terminator code for carriage return alone
  localparam logic [7:0] TERM_CR = 8'h0d;
  localparam logic [7:0] TERM_RESET = 8'h0d;
  // Serial poll handshake states
  typedef enum logic [1:0] {GSRP_IDLE, GSRP_SHOW, GSRP_DONE} gsrp_sp_t;
endpackage

/* logic/gsrp_msg_len.sv */
// Counts received message characters and flags an overlong message
module gsrp_msg_len (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Receive stream
  input wire logic char_valid,
  input wire logic msg_end,
  // Result
  output logic too_long
);
  import gsrp_pkg::*;
  logic [7:0] count_r;

  // Count characters, saturating just above the limit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 8'h00;
    end else if (msg_end) begin
      count_r <= 8'h00;
    end else if (char_valid && count_r <= MSG_MAX) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Pulse once when a message ends past the limit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      too_long <= 1'b0;
    end else begin
      too_long <= msg_end && (count_r > MSG_MAX);
    end
  end
endmodule // gsrp_msg_len

/* logic/gsrp_poll.sv */
// Contract
// - On serial poll enable with talk address, the status byte goes out.
// - Status byte: 7 request, 6 error, 5 ready, 4 output, 3 user, 2:1 code.
// - Bit 6 is set while an error exists; code bits give its kind.
// - Codes: 00 interpret, 01 execute, 10 calibration, 11 overlong message.
// - A received message over 76 characters is an overlong error.
// - Request service sets bit 7 and the request line together.
// - Enable command picks sources; value zero blocks all requests and bit 7.
// - Output enabled and data available sets bit 4 and requests service.
// - User enabled and panel key pressed sets bit 3 and requests service.
// - Ready enabled and not busy sets bit 5 and requests service.
// - Ready request only after triggered measurements end, awaiting command.
// - Ready and output flags are independent and may both be set.
// - Invalid message keeps settings, writes code, requests service; code guards only the enable mask, not lockout or terminator.
// - Parallel poll follows PP1; one of eight data lines assignable.
// - Three-bit field in parallel poll enable selects the data line.
// - Sense one drives the line only while requesting service.
// - Sense zero drives the line only while not requesting service.
// - Status query queues an error message as output.
// - Lockout on or off disables or enables the local key.
// - Terminator command takes a code; 13 selects carriage return alone.
module gsrp_poll (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Controller bus events
  input wire logic spe_talk,
  input wire logic spd,
  input wire logic sp_byte_taken,
  input wire logic pp_configure,
  input wire logic pp_enable,
  input wire logic [3:0] pp_enable_field,
  input wire logic pp_disable,
  input wire logic pp_identify,
  // Decoded device commands
  input wire logic srq_cmd_valid,
  input wire logic [3:0] srq_cmd_mask,
  input wire logic status_query,
  input wire logic lockout_valid,
  input wire logic lockout_on,
  input wire logic term_valid,
  input wire logic [7:0] term_code,
  // Receive stream and error sources
  input wire logic char_valid,
  input wire logic msg_end,
  input wire logic err_event,
  input wire logic [1:0] err_code,
  input wire logic cal_fault,
  // Instrument state
  input wire logic output_avail,
  input wire logic busy,
  input wire logic trig_pending,
  input wire logic user_key,
  // Bus outputs
  output logic srq_o,
  output logic [7:0] dio_o,
  output logic [7:0] dio_oe,
  // Instrument outputs
  output logic [7:0] status_byte,
  output logic err_msg_queue,
  output logic cmd_reject,
  output logic local_key_en,
  output logic [7:0] term_char_r,
  output logic term_cr_only
);
  import gsrp_pkg::*;

  logic [3:0] en_r;
  logic err_r;
  logic [1:0] abn_r;
  logic usr_r;
  logic [2:0] ppl_r;
  logic pps_r;
  logic ppen_r;
  logic ppcfg_r;
  logic rqs_r;
  logic too_long;
  logic rdy_now;
  logic out_now;
  logic any_err;
  logic [1:0] code_nxt;
  logic want_rqs;
  logic rqs_nxt;
  logic [7:0] stb_nxt;
  logic sp_show;
  logic pp_answer;
  logic [7:0] pp_oe_nxt;
  gsrp_sp_t sp_r;

  // One-hot decode of a poll line number
  function automatic logic [7:0] line_mask(input logic [2:0] idx);
    line_mask = 8'h01 << idx;
  endfunction

  // A sticky flag survives unless the controller reads the byte now
  function automatic logic held(input logic flag, input logic taken);
    held = flag && !taken;
  endfunction

  // Overlong message detector
  gsrp_msg_len gsrp_msg_len_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .char_valid(char_valid),
    .msg_end(msg_end),
    .too_long(too_long)
  );

  // Error source selection; overlong beats calibration beats parser codes
  always_comb begin
    any_err = err_event || cal_fault || too_long;
    if (too_long) begin
      code_nxt = ABN_LONG;
    end else if (cal_fault) begin
      code_nxt = ABN_CAL;
    end else begin
      code_nxt = err_code;
    end
  end

  // Live flags; ready waits for all triggered work to finish
  assign rdy_now = !busy && !trig_pending;
  assign out_now = output_avail || err_msg_queue;

  // Service request enable mask; an invalid message leaves it alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= EN_RESET;
    end else if (srq_cmd_valid && !err_event) begin
      en_r <= srq_cmd_mask;
    end
  end

  // Error flag sticky until a serial poll reads it; code kept until the next error
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 1'b0;
      abn_r <= ABN_INTERP;
    end else if (any_err) begin
      err_r <= 1'b1;
      abn_r <= code_nxt;
    end else if (sp_byte_taken) begin
      err_r <= 1'b0;
    end
  end

  // User key latch; a new press wins over the poll clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      usr_r <= 1'b0;
    end else if (user_key && en_r[EN_USR]) begin
      usr_r <= 1'b1;
    end else if (sp_byte_taken) begin
      usr_r <= 1'b0;
    end
  end

  // Request condition from enabled sources
  always_comb begin
    want_rqs = (en_r[EN_ERR] && any_err)
      || (en_r[EN_OUT] && out_now && !status_byte[BIT_OUT])
      || (en_r[EN_USR] && user_key)
      || (en_r[EN_RDY] && rdy_now && !status_byte[BIT_RDY]);
  end

  // Request flag: set wins over poll clear; mask of zero forces it off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rqs_r <= 1'b0;
    end else if (en_r == EN_RESET) begin
      rqs_r <= 1'b0;
    end else if (want_rqs) begin
      rqs_r <= 1'b1;
    end else if (sp_byte_taken) begin
      rqs_r <= 1'b0;
    end
  end

  // Request level shared by bit 7 and the bus line; zero mask forces it off
  always_comb begin
    if (en_r == EN_RESET) begin
      rqs_nxt = 1'b0;
    end else begin
      rqs_nxt = want_rqs || held(rqs_r, sp_byte_taken);
    end
  end

  // Next status byte; ready and output bits kept apart
  always_comb begin
    stb_nxt = STB_RESET;
    stb_nxt[BIT_RQS] = rqs_nxt;
    stb_nxt[BIT_ERR] = any_err || held(err_r, sp_byte_taken);
    stb_nxt[BIT_RDY] = en_r[EN_RDY] && rdy_now;
    stb_nxt[BIT_OUT] = en_r[EN_OUT] && out_now;
    stb_nxt[BIT_USR] = (user_key && en_r[EN_USR])
      || held(usr_r, sp_byte_taken);
    stb_nxt[ABN_HI:ABN_LO] = any_err ? code_nxt : abn_r;
    stb_nxt[0] = 1'b0; // Unused bit reads zero
  end

  // Status byte register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_byte <= STB_RESET;
    end else begin
      status_byte <= stb_nxt;
    end
  end

  // Service request line rises with bit 7
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srq_o <= 1'b0;
    end else begin
      srq_o <= rqs_nxt;
    end
  end

  // Status query queues an error message until a poll reads it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_msg_queue <= 1'b0;
    end else if (status_query) begin
      err_msg_queue <= 1'b1;
    end else if (sp_byte_taken) begin
      err_msg_queue <= 1'b0;
    end
  end

  // Rejected command pulse tells the engine to keep its settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= err_event;
    end
  end

  // Local key lockout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_key_en <= 1'b1;
    end else if (lockout_valid) begin
      local_key_en <= !lockout_on;
    end
  end

  // Output terminator code
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_char_r <= TERM_RESET;
      term_cr_only <= 1'b1;
    end else if (term_valid) begin
      term_char_r <= term_code;
      term_cr_only <= (term_code == TERM_CR);
    end
  end

  // Parallel poll configuration: configure arms, enable loads line and sense
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ppcfg_r <= 1'b0;
      ppen_r <= 1'b0;
      ppl_r <= PPL_RESET;
      pps_r <= 1'b0;
    end else if (pp_disable) begin
      ppen_r <= 1'b0;
      ppcfg_r <= 1'b0;
    end else if (pp_configure) begin
      ppcfg_r <= 1'b1;
    end else if (pp_enable && ppcfg_r) begin
      ppen_r <= 1'b1;
      ppl_r <= pp_enable_field[2:0];
      pps_r <= pp_enable_field[PPE_SENSE];
      ppcfg_r <= 1'b0;
    end
  end

  // Serial poll state: show byte while addressed, move to done on read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= GSRP_IDLE;
    end else begin
      case (sp_r)
        GSRP_IDLE: begin
          if (spe_talk) begin
            sp_r <= GSRP_SHOW;
          end
        end
        GSRP_SHOW: begin
          if (spd) begin
            sp_r <= GSRP_IDLE;
          end else if (sp_byte_taken) begin
            sp_r <= GSRP_DONE;
          end
        end
        GSRP_DONE: begin
          if (spd) begin
            sp_r <= GSRP_IDLE;
          end else if (spe_talk) begin
            sp_r <= GSRP_SHOW;
          end
        end
        default: begin
          sp_r <= GSRP_IDLE;
        end
      endcase
    end
  end

  // Identify on a configured line beats a serial poll
  assign pp_answer = pp_identify && ppen_r;

  // Serial answer from any enable, also a repeat poll after a read
  assign sp_show = (sp_r == GSRP_SHOW) || spe_talk;

  // Parallel poll line: driven only when sense matches the request state
  always_comb begin
    if (pps_r == rqs_r) begin
      pp_oe_nxt = line_mask(ppl_r);
    end else begin
      pp_oe_nxt = 8'h00;
    end
  end

  // Data line drive: status byte on serial poll, one line on identify
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dio_o <= 8'h00;
      dio_oe <= 8'h00;
    end else if (pp_answer) begin
      dio_o <= line_mask(ppl_r);
      dio_oe <= pp_oe_nxt;
    end else if (sp_show) begin
      dio_o <= status_byte;
      dio_oe <= 8'hff;
    end else begin
      dio_o <= 8'h00;
      dio_oe <= 8'h00;
    end
  end
endmodule // gsrp_poll

/* sim/gsrp_poll_properties.sv */
// Watches the poll block at its ports
module gsrp_poll_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Causes
  input wire logic spe_talk,
  input wire logic sp_byte_taken,
  input wire logic pp_identify,
  input wire logic srq_cmd_valid,
  input wire logic [3:0] srq_cmd_mask,
  input wire logic err_event,
  input wire logic [1:0] err_code,
  input wire logic busy,
  input wire logic trig_pending,
  input wire logic user_key,
  // Effects
  input wire logic srq_o,
  input wire logic [7:0] dio_o,
  input wire logic [7:0] dio_oe,
  input wire logic [7:0] status_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  import gsrp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] mask_r;
  // Copy of the source mask; an invalid message blocks the load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= EN_RESET;
    end else if (srq_cmd_valid && !err_event) begin
      mask_r <= srq_cmd_mask;
    end
  end
  // Serial poll start, and a parallel poll held two cycles
  sequence s_sp_take;
    spe_talk && !pp_identify;
  endsequence
  sequence s_ident;
    pp_identify ##1 pp_identify;
  endsequence
  chk_srq_flag: assert property (srq_o == status_byte[BIT_RQS])
    else $error("srq line and flag differ");
  chk_err_code: assert property (err_event |=>
    status_byte[BIT_ERR] && status_byte[ABN_HI:ABN_LO] == $past(err_code))
    else $error("error flag or code wrong");
  chk_mask_zero: assert property (mask_r == EN_RESET && !srq_o |=> !srq_o)
    else $error("request with mask zero");
  chk_sp_answer: assert property (s_sp_take |=>
    dio_oe == 8'hff && dio_o == $past(status_byte))
    else $error("serial poll byte wrong");
  chk_sp_clear: assert property (sp_byte_taken && !err_event |=> !srq_o)
    else $error("request kept after poll");
  chk_user_key: assert property ($rose(user_key) && mask_r[EN_USR] |=>
    status_byte[BIT_USR] && srq_o)
    else $error("user key ignored");
  chk_ready_rise: assert property (
    $rose(!busy && !trig_pending) && mask_r[EN_RDY] |=>
    status_byte[BIT_RDY] && srq_o)
    else $error("ready ignored");
  chk_pp_one_line: assert property (s_ident |-> $onehot0(dio_oe))
    else $error("more than one poll line");
endmodule // gsrp_poll_properties

/* sim/gsrp_ctrl_model.sv */
// Bus controller side: serial and parallel polls
module gsrp_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Poll events toward the device
  output logic spe_talk,
  output logic spd,
  output logic sp_byte_taken,
  output logic pp_configure,
  output logic pp_enable,
  output logic [3:0] pp_enable_field,
  output logic pp_disable,
  output logic pp_identify,
  // Device data lines
  input wire logic [7:0] dio_o,
  input wire logic [7:0] dio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import gsrp_pkg::*;
  // All events idle at start
  initial begin
    {spe_talk, spd, sp_byte_taken, pp_configure, pp_enable} = 5'h0;
    {pp_enable_field, pp_disable, pp_identify} = 6'h0;
  end
  // Enable, take the byte, then accept it
  task automatic serial_poll(output logic [7:0] sb);
    @(posedge ref_clk) #1 spe_talk = 1;
    @(posedge ref_clk) #1 spe_talk = 0;
    sb = (dio_oe === 8'hff) ? dio_o : 8'hxx;
    sp_byte_taken = 1;
    @(posedge ref_clk) #1 sp_byte_taken = 0;
  endtask
  // Enable, then disable before the byte is taken
  task automatic serial_abort(output logic [7:0] oe);
    @(posedge ref_clk) #1 spe_talk = 1;
    @(posedge ref_clk) #1 spe_talk = 0;
    spd = 1;
    @(posedge ref_clk) #1 spd = 0;
    @(posedge ref_clk) #1 oe = dio_oe;
  endtask
  // Configure first, then enable with line and sense
  task automatic par_poll(input logic [3:0] f, output logic [7:0] oe);
    @(posedge ref_clk) #1 pp_configure = 1;
    @(posedge ref_clk) #1 pp_configure = 0;
    pp_enable = 1;
    pp_enable_field = f;
    @(posedge ref_clk) #1 pp_enable = 0;
    pp_enable_field = ~f;
    pp_identify = 1;
    repeat (2) @(posedge ref_clk);
    #1 oe = dio_oe;
    pp_identify = 0;
  endtask
endmodule // gsrp_ctrl_model

/* sim/test_gsrp_poll.sv */
bind gsrp_poll gsrp_poll_properties gsrp_poll_properties_inst (
  .ref_clk, .rst_n, .spe_talk, .sp_byte_taken, .pp_identify,
  .srq_cmd_valid, .srq_cmd_mask, .err_event, .err_code, .busy,
  .trig_pending, .user_key, .srq_o, .dio_o, .dio_oe, .status_byte);
module test_gsrp_poll;
  timeunit 1ns;
  timeprecision 100ps;
  import gsrp_pkg::*;
  logic ref_clk, rst_n, spe_talk, spd, sp_byte_taken, pp_configure;
  logic pp_enable, pp_disable, pp_identify, srq_cmd_valid, status_query;
  logic lockout_valid, lockout_on, term_valid, char_valid, msg_end;
  logic err_event, cal_fault, output_avail, busy, trig_pending, user_key;
  logic srq_o, err_msg_queue, cmd_reject, local_key_en, term_cr_only;
  logic [3:0] pp_enable_field, srq_cmd_mask;
  logic [1:0] err_code;
  logic [7:0] term_code, dio_o, dio_oe, status_byte, term_char_r, sb;
  int mismatches, total_checks, cycles;
  // Device and bus controller
  gsrp_poll gsrp_poll_inst (.ref_clk, .rst_n, .spe_talk, .spd,
    .sp_byte_taken, .pp_configure, .pp_enable, .pp_enable_field,
    .pp_disable, .pp_identify, .srq_cmd_valid, .srq_cmd_mask,
    .status_query, .lockout_valid, .lockout_on, .term_valid, .term_code,
    .char_valid, .msg_end, .err_event, .err_code, .cal_fault,
    .output_avail, .busy, .trig_pending, .user_key, .srq_o, .dio_o,
    .dio_oe, .status_byte, .err_msg_queue, .cmd_reject, .local_key_en,
    .term_char_r, .term_cr_only);
  gsrp_ctrl_model gsrp_ctrl_model_inst (.ref_clk, .spe_talk, .spd,
    .sp_byte_taken, .pp_configure, .pp_enable, .pp_enable_field,
    .pp_disable, .pp_identify, .dio_o, .dio_oe);
  // Clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Step to just after a later rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reset held five cycles
  task automatic do_reset();
    rst_n = 0;
    tick(5);
    rst_n = 1;
  endtask
  // Load the source mask
  task automatic cmd_mask(input logic [3:0] m);
    srq_cmd_mask = m;
    srq_cmd_valid = 1;
    tick(1);
    srq_cmd_valid = 0;
  endtask
  // Flagged error must be read back, then the request dropped
  task automatic poll_err(input logic [1:0] c);
    check("stb", 8'hc0 | {5'h0, c, 1'b0}, status_byte);
    check("srq", 8'h1, {7'h0, srq_o});
    gsrp_ctrl_model_inst.serial_poll(sb);
    check("byte", 8'hc0 | {5'h0, c, 1'b0}, sb);
    check("srq off", 8'h0, {7'h0, srq_o});
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Test sequence
  initial begin
    ref_clk = 0;
    {srq_cmd_valid, status_query, lockout_valid, lockout_on} = 4'h0;
    {term_valid, char_valid, msg_end, err_event, cal_fault} = 5'h0;
    {output_avail, busy, trig_pending, user_key} = 4'h0;
    {srq_cmd_mask, err_code, term_code} = 14'h0;
    do_reset();
    check("stb", STB_RESET, status_byte);
    check("key", 8'h1, {7'h0, local_key_en});
    check("term", TERM_RESET, term_char_r);
    $display("reset test done");
    srq_cmd_mask = 4'hf;
    srq_cmd_valid = 1;
    err_event = 1;
    tick(1);
    srq_cmd_valid = 0;
    err_event = 0;
    check("reject", 8'h1, {7'h0, cmd_reject});
    tick(2);
    check("masked", 8'h0, {srq_o, status_byte[7], 6'h0});
    $display("mask test done");
    do_reset();
    cmd_mask(4'h1);
    for (int i = 0; i < 3; i++) begin
      err_code = i[1:0];
      err_event = (i < 2);
      cal_fault = (i == 2);
      tick(1);
      err_event = 0;
      cal_fault = 0;
      tick(1);
      poll_err(i[1:0]);
    end
    for (int n = 76; n < 78; n++) begin
      repeat (n) begin
        char_valid = 1;
        tick(1);
        char_valid = 0;
        tick(1);
      end
      msg_end = 1;
      tick(1);
      msg_end = 0;
      tick(3);
      if (n == 76) begin
        check("76 chars", 8'h0, {7'h0, srq_o});
      end else begin
        poll_err(ABN_LONG);
      end
    end
    $display("error test done");
    do_reset();
    busy = 1;
    cmd_mask(4'h8);
    tick(2);
    check("busy", 8'h00, status_byte);
    cmd_mask(4'h2);
    output_avail = 1;
    tick(2);
    check("output", 8'h90, status_byte);
    cmd_mask(4'ha);
    busy = 0;
    trig_pending = 1;
    tick(2);
    check("trig", 8'h90, status_byte);
    trig_pending = 0;
    tick(2);
    check("ready", 8'hb0, status_byte);
    gsrp_ctrl_model_inst.serial_poll(sb);
    check("byte", 8'hb0, sb);
    check("held", 8'h30, status_byte);
    cmd_mask(4'h4);
    user_key = 1;
    tick(1);
    user_key = 0;
    tick(1);
    check("user", 8'h88, status_byte);
    $display("source test done");
    do_reset();
    cmd_mask(4'h1);
    err_event = 1;
    tick(1);
    err_event = 0;
    for (int r = 1; r >= 0; r--) begin
      for (int f = 0; f < 16; f++) begin
        gsrp_ctrl_model_inst.par_poll(f[3:0], sb);
        check("pp", (f[3] == r[0]) ? 8'h1 << f[2:0] : 8'h0, sb);
      end
      gsrp_ctrl_model_inst.serial_poll(sb);
    end
    $display("parallel poll test done");
    do_reset();
    cmd_mask(4'h2);
    status_query = 1;
    tick(1);
    status_query = 0;
    tick(2);
    check("query", 8'h91, {status_byte[7:4], 3'h0, err_msg_queue});
    for (int k = 1; k >= 0; k--) begin
      lockout_on = k[0];
      lockout_valid = 1;
      term_code = k[0] ? 8'h0a : TERM_CR;
      term_valid = 1;
      tick(1);
      lockout_valid = 0;
      term_valid = 0;
      tick(1);
      check("key", {7'h0, !k[0]}, {7'h0, local_key_en});
      check("cr", {7'h0, !k[0]}, {7'h0, term_cr_only});
      check("code", term_code, term_char_r);
    end
    gsrp_ctrl_model_inst.serial_abort(sb);
    check("spd", 8'h0, sb);
    check("srq kept", 8'h1, {7'h0, srq_o});
    $display("command test done");
    give_verdict();
  end
endmodule // test_gsrp_poll
